// [src/interval_counter_defines.svh]
// Constants for the interval counter channel
`ifndef INTERVAL_COUNTER_DEFINES_SVH
`define INTERVAL_COUNTER_DEFINES_SVH

`define MODE_TERMINAL 3'h0
`define MODE_ONE_SHOT 3'h1
`define MODE_RATE 3'h2
`define MODE_SQUARE 3'h3
`define MODE_SW_STROBE 3'h4
`define MODE_HW_STROBE 3'h5

`define COUNT_RESET 16'h0000
`define OUT_RESET 1'b1
`define MODE_RESET 3'h0

`define STEP_ONE 2'h1
`define STEP_TWO 2'h2
`define STEP_THREE 2'h3

`define BCD_DIGIT_MAX 4'h9
`define BCD_DIGIT_BASE 5'h0a

`endif

// [src/interval_counter_pkg.sv]
// Types shared by the interval counter modules
package interval_counter_pkg;
  typedef logic [15:0] count_t;
  typedef logic [2:0] mode_t;
  typedef enum logic {BYTE_LOW, BYTE_HIGH} byte_phase_e;
endpackage

// [src/edge_if.sv]
// Level and edge pulses of one sampled input
`timescale 1ns/1ns
interface edge_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

// [src/edge_sense.sv]
// Edge detector for one synchronous input
`timescale 1ns/1ns
module edge_sense (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic sig_in,
  edge_if.src edges
);
  logic prev_r;
  logic prev_nxt;

  always_comb begin
    prev_nxt = sig_in;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
    end
  end

  assign edges.level = sig_in;
  assign edges.rise = sig_in & ~prev_r;
  assign edges.fall = ~sig_in & prev_r;
endmodule

// [src/count_step.sv]
// Binary or decimal-coded down step with wrap
`timescale 1ns/1ns
`include "interval_counter_defines.svh"
module count_step
  import interval_counter_pkg::*;
(
  input wire count_t value,
  input wire logic [1:0] step,
  input wire logic bcd,
  output count_t result
);
  logic [4:0] digit;
  logic borrow;

  always_comb begin
    digit = 5'h00;
    borrow = 1'b0;
    result = value - {14'h0000, step};
    if (bcd) begin
      for (int i = 0; i < 4; i++) begin
        digit = {1'b0, value[4*i +: 4]} - (i == 0 ? {3'h0, step} : 5'h00) - {4'h0, borrow};
        borrow = digit[4];
        if (borrow) begin
          digit = digit + `BCD_DIGIT_BASE;
        end
        result[4*i +: 4] = digit[3:0];
      end
    end
  end
endmodule

// [src/interval_counter.sv]
// One counter channel: square wave and strobe modes
//
// Behaviour
// - Mode 3 square wave starts high, low after half count, period N.
// - Mode 3 low gate suspends counting; gate low with output low forces high.
// - Mode 3 trigger or fresh count write loads on next count-clock pulse.
// - Mode 3 rewritten count loads at half-cycle end, or next pulse on trigger.
// - Mode 3 even count: load, step by two, toggle and reload on expiry.
// - Mode 3 odd count: one then twos high, three then twos low.
// - Mode 4 starts high; count write starts; expiry gives one-pulse low strobe.
// - Mode 4 load pulse does not decrement; strobe N+1 pulses after write.
// - Mode 4 first byte of two leaves counting alone; second byte retriggers.
// - Mode 5 starts high; gate rise starts; one-pulse strobe; gate never drives output.
// - Mode 5 loads on pulse after trigger without decrement; strobe N+1 later.
// - Mode 5 new count waits; trigger before expiry loads it next pulse.
// - Setup word resets control and sets output at once.
// - Gate level sampled on count-clock rise enables counting in level modes.
// - Gate rise sets a latch, sampled at next clock rise then cleared.
// - Loading and decrementing happen on count-clock falling edge.
// - Zero count acts as maximum, 65536 binary or 10000 decimal.
// - Modes 4, 5 wrap to all-nines or FFFF and continue; modes 0, 1 hold the count.
// - Mode 3 gate low forces output high; rising gate starts counting.
// - A count-clock pulse is a rise followed by a fall.
// - Loading copies the count holding register into the counting element.
// - A trigger is a rising edge of the gate.
`timescale 1ns/1ns
`include "interval_counter_defines.svh"
module interval_counter
  import interval_counter_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic cnt_clk,
  input wire logic gate_in,
  input wire logic setup_wr,
  input wire mode_t setup_mode,
  input wire logic setup_bcd,
  input wire logic setup_two_byte,
  input wire logic count_wr,
  input wire logic [7:0] count_byte,
  output logic cnt_out_r,
  output count_t count_value_r,
  output logic counting_r
);

  ////////////////////////////////////////////////////////////////////////
  // Edge sensing
  edge_if clk_e ();
  edge_if gate_e ();

  edge_sense u_clk_sense (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .sig_in(cnt_clk),
    .edges(clk_e)
  );

  edge_sense u_gate_sense (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .sig_in(gate_in),
    .edges(gate_e)
  );

  logic cclk_rise;
  logic cclk_fall;
  assign cclk_rise = clk_e.rise;
  assign cclk_fall = clk_e.fall;

  ////////////////////////////////////////////////////////////////////////
  // Gate sampling and trigger latch
  logic gate_lvl_r;
  logic gate_lvl_nxt;
  logic trig_latch_r;
  logic trig_latch_nxt;
  logic trig_seen_r;
  logic trig_seen_nxt;

  always_comb begin
    gate_lvl_nxt = gate_lvl_r;
    trig_seen_nxt = trig_seen_r;
    trig_latch_nxt = trig_latch_r;
    if (cclk_rise) begin
      gate_lvl_nxt = gate_in;
      trig_seen_nxt = trig_latch_r;
      trig_latch_nxt = 1'b0;
    end
    if (cclk_fall) begin
      trig_seen_nxt = 1'b0;
    end
    if (gate_e.rise) begin
      trig_latch_nxt = 1'b1;
    end
    if (setup_wr) begin
      trig_seen_nxt = 1'b0;
      trig_latch_nxt = gate_e.rise;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      gate_lvl_r <= 1'b0;
      trig_latch_r <= 1'b0;
      trig_seen_r <= 1'b0;
    end else begin
      gate_lvl_r <= gate_lvl_nxt;
      trig_latch_r <= trig_latch_nxt;
      trig_seen_r <= trig_seen_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Setup and count holding register
  mode_t mode_r;
  mode_t mode_nxt;
  logic bcd_r;
  logic bcd_nxt;
  logic two_byte_r;
  logic two_byte_nxt;
  byte_phase_e phase_r;
  byte_phase_e phase_nxt;
  count_t count_holding_register_r;
  count_t count_holding_register_nxt;
  logic count_done;

  always_comb begin
    mode_nxt = mode_r;
    bcd_nxt = bcd_r;
    two_byte_nxt = two_byte_r;
    phase_nxt = phase_r;
    count_holding_register_nxt = count_holding_register_r;
    count_done = 1'b0;
    if (setup_wr) begin
      mode_nxt = setup_mode;
      bcd_nxt = setup_bcd;
      two_byte_nxt = setup_two_byte;
      phase_nxt = BYTE_LOW;
    end else if (count_wr) begin
      case (phase_r)
        BYTE_LOW: begin
          count_holding_register_nxt[7:0] = count_byte;
          if (two_byte_r) begin
            phase_nxt = BYTE_HIGH;
          end else begin
            count_holding_register_nxt[15:8] = 8'h00;
            count_done = 1'b1;
          end
        end
        BYTE_HIGH: begin
          count_holding_register_nxt[15:8] = count_byte;
          phase_nxt = BYTE_LOW;
          count_done = 1'b1;
        end
        default: begin
          phase_nxt = BYTE_LOW;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_r <= `MODE_RESET;
      bcd_r <= 1'b0;
      two_byte_r <= 1'b0;
      phase_r <= BYTE_LOW;
      count_holding_register_r <= `COUNT_RESET;
    end else begin
      mode_r <= mode_nxt;
      bcd_r <= bcd_nxt;
      two_byte_r <= two_byte_nxt;
      phase_r <= phase_nxt;
      count_holding_register_r <= count_holding_register_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Counting element and output
  logic load_pend_r;
  logic load_pend_nxt;
  logic first_r;
  logic first_nxt;
  logic cnt_out_nxt;
  logic counting_nxt;
  count_t count_value_nxt;
  logic [1:0] step;
  count_t stepped;

  // zero wraps below to the maximum
  count_step u_step (
    .value(count_value_r),
    .step(step),
    .bcd(bcd_r),
    .result(stepped)
  );

  always_comb begin
    step = `STEP_ONE;
    if (mode_r == `MODE_SQUARE) begin
      if (first_r && count_value_r[0]) begin
        step = cnt_out_r ? `STEP_ONE : `STEP_THREE;
      end else begin
        step = `STEP_TWO;
      end
    end
  end

  always_comb begin
    load_pend_nxt = load_pend_r;
    first_nxt = first_r;
    cnt_out_nxt = cnt_out_r;
    counting_nxt = counting_r;
    count_value_nxt = count_value_r;
    if (setup_wr) begin
      load_pend_nxt = 1'b0;
      counting_nxt = 1'b0;
      first_nxt = 1'b0;
      cnt_out_nxt = (setup_mode != `MODE_TERMINAL);
    end else begin
      if (cclk_fall) begin
        case (mode_r)
          `MODE_SQUARE: begin
            if (trig_seen_r || load_pend_r) begin
              count_value_nxt = count_holding_register_r;
              load_pend_nxt = 1'b0;
              counting_nxt = 1'b1;
              first_nxt = 1'b1;
              cnt_out_nxt = 1'b1;
            end else if (counting_r && gate_lvl_r) begin
              if (stepped == 16'h0000) begin
                cnt_out_nxt = ~cnt_out_r;
                count_value_nxt = count_holding_register_r;
                first_nxt = 1'b1;
              end else begin
                count_value_nxt = stepped;
                first_nxt = 1'b0;
              end
            end
          end
          `MODE_SW_STROBE: begin
            cnt_out_nxt = 1'b1;
            if (load_pend_r) begin
              count_value_nxt = count_holding_register_r;
              load_pend_nxt = 1'b0;
              counting_nxt = 1'b1;
            end else if (gate_lvl_r) begin
              count_value_nxt = stepped;
              if (counting_r && stepped == 16'h0000) begin
                cnt_out_nxt = 1'b0;
                counting_nxt = 1'b0;
              end
            end
          end
          `MODE_HW_STROBE: begin
            cnt_out_nxt = 1'b1;
            if (trig_seen_r) begin
              count_value_nxt = count_holding_register_r;
              counting_nxt = 1'b1;
            end else begin
              count_value_nxt = stepped;
              if (counting_r && stepped == 16'h0000) begin
                cnt_out_nxt = 1'b0;
                counting_nxt = 1'b0;
              end
            end
          end
          default: begin
            count_value_nxt = count_value_r;
          end
        endcase
      end
      if (count_done && (mode_r == `MODE_SW_STROBE || (mode_r == `MODE_SQUARE && !counting_r))) begin
        load_pend_nxt = 1'b1;
      end
      if (mode_r == `MODE_SQUARE && !gate_in) begin
        cnt_out_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      load_pend_r <= 1'b0;
      first_r <= 1'b0;
      cnt_out_r <= `OUT_RESET;
      counting_r <= 1'b0;
      count_value_r <= `COUNT_RESET;
    end else begin
      load_pend_r <= load_pend_nxt;
      first_r <= first_nxt;
      cnt_out_r <= cnt_out_nxt;
      counting_r <= counting_nxt;
      count_value_r <= count_value_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  property p_setup_out;
    setup_wr && setup_mode == `MODE_SQUARE |=> cnt_out_r && !counting_r;
  endproperty
  a_setup_out: assert property (p_setup_out) else $error("setup word did not reset output");
  property p_sq_gate_high;
    !setup_wr && mode_r == `MODE_SQUARE && !gate_in && !cnt_out_r |=> cnt_out_r;
  endproperty
  a_sq_gate_high: assert property (p_sq_gate_high) else $error("gate low did not force output high");
  property p_fall_only;
    !cclk_fall && !setup_wr |=> $stable(count_value_r);
  endproperty
  a_fall_only: assert property (p_fall_only) else $error("count changed off a falling edge");
  property p_trig_latch;
    gate_e.rise |=> trig_latch_r;
  endproperty
  a_trig_latch: assert property (p_trig_latch) else $error("gate rise lost");
  property p_sw_load;
    cclk_fall && !setup_wr && !count_wr && load_pend_r && mode_r == `MODE_SW_STROBE
      |=> count_value_r == $past(count_holding_register_r) && counting_r;
  endproperty
  a_sw_load: assert property (p_sw_load) else $error("load did not copy holding register");
  property p_hold_count;
    cclk_fall && !setup_wr && mode_r == `MODE_SW_STROBE && !load_pend_r && !gate_lvl_r
      |=> $stable(count_value_r);
  endproperty
  a_hold_count: assert property (p_hold_count) else $error("count moved while gate low");
  property p_sw_strobe_len;
    !setup_wr && mode_r == `MODE_SW_STROBE && !cnt_out_r && cclk_fall |=> cnt_out_r;
  endproperty
  a_sw_strobe_len: assert property (p_sw_strobe_len) else $error("strobe longer than one pulse");
  property p_hw_gate_free;
    !setup_wr && mode_r == `MODE_HW_STROBE && !cclk_fall |=> $stable(cnt_out_r);
  endproperty
  a_hw_gate_free: assert property (p_hw_gate_free) else $error("output moved without a pulse");
  property p_sq_even_step;
    cclk_fall && !setup_wr && mode_r == `MODE_SQUARE && counting_r && gate_lvl_r && !trig_seen_r
      && !load_pend_r && !count_value_r[0] && count_value_r > 16'h0002 && !bcd_r
      |=> count_value_r == $past(count_value_r) - 16'h0002;
  endproperty
  a_sq_even_step: assert property (p_sq_even_step) else $error("even square count not stepped by two");

  c_sq_toggle: cover property (mode_r == `MODE_SQUARE && $fell(cnt_out_r) && gate_lvl_r);
  c_sw_strobe: cover property (mode_r == `MODE_SW_STROBE && $fell(cnt_out_r));
  c_hw_strobe: cover property (mode_r == `MODE_HW_STROBE && $fell(cnt_out_r));
  c_sq_gate_force: cover property (mode_r == `MODE_SQUARE && !gate_in && !cnt_out_r);

endmodule

// [tb/count_source.sv]
// Far-side model: count clock pulses and gate level
`timescale 1ns/1ns
module count_source (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic pulse_go,
  input wire logic gate_set,
  output logic cnt_clk,
  output logic gate_in,
  output logic busy
);
  logic [2:0] phase_r;
  logic gate_r;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_r <= 3'h0;
      gate_r <= 1'b0;
    end else begin
      gate_r <= gate_set;
      if (pulse_go && phase_r == 3'h0) begin
        phase_r <= 3'h4;
      end else if (phase_r != 3'h0) begin
        phase_r <= phase_r - 3'h1;
      end
    end
  end
  assign cnt_clk = (phase_r == 3'h4) || (phase_r == 3'h3);
  assign gate_in = gate_r;
  assign busy = phase_r != 3'h0;
endmodule

// [tb/test_interval_counter.sv]
// Self-checking bench for the interval counter channel
`timescale 1ns/1ns
module test_interval_counter
  import interval_counter_pkg::*;
;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic pulse_go = 1'b0;
  logic gate_set = 1'b1;
  logic setup_wr = 1'b0;
  mode_t setup_mode = 3'h0;
  logic setup_bcd = 1'b0;
  logic setup_two_byte = 1'b0;
  logic count_wr = 1'b0;
  logic [7:0] count_byte = 8'h00;
  logic cnt_clk, gate_in, busy, cnt_out_r, counting_r;
  count_t count_value_r;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  count_source far (.core_clk(core_clk), .arst_n(arst_n), .pulse_go(pulse_go), .gate_set(gate_set),
    .cnt_clk(cnt_clk), .gate_in(gate_in), .busy(busy));
  interval_counter dut (.core_clk(core_clk), .arst_n(arst_n), .cnt_clk(cnt_clk), .gate_in(gate_in),
    .setup_wr(setup_wr), .setup_mode(setup_mode), .setup_bcd(setup_bcd), .setup_two_byte(setup_two_byte),
    .count_wr(count_wr), .count_byte(count_byte), .cnt_out_r(cnt_out_r), .count_value_r(count_value_r),
    .counting_r(counting_r));
  ////////////////////////////////////////////////////////////////
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (failures == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string what, input count_t exp, input count_t got);
    checked++;
    if (exp !== got) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic setup(input mode_t m, input logic b, input logic two);
    @(posedge core_clk);
    setup_wr <= 1'b1;
    setup_mode <= m;
    setup_bcd <= b;
    setup_two_byte <= two;
    @(posedge core_clk);
    setup_wr <= 1'b0;
    @(posedge core_clk);
    #1;
    chk("out after setup", {15'h0000, m != 3'h0}, {15'h0000, cnt_out_r});
    chk("counting after setup", 16'h0000, {15'h0000, counting_r});
  endtask
  task automatic wr(input logic [7:0] d);
    @(posedge core_clk);
    count_wr <= 1'b1;
    count_byte <= d;
    @(posedge core_clk);
    count_wr <= 1'b0;
  endtask
  task automatic gate(input logic g);
    @(posedge core_clk);
    gate_set <= g;
  endtask
  // One count-clock pulse, then out and (when asked) value compared
  task automatic pc(input logic cv, input count_t v, input logic o);
    int n;
    @(posedge core_clk);
    pulse_go <= 1'b1;
    @(posedge core_clk);
    pulse_go <= 1'b0;
    @(posedge core_clk);
    n = 0;
    while (busy !== 1'b0 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    repeat (2) @(posedge core_clk);
    #1;
    if (cv) begin
      chk("count value", v, count_value_r);
    end
    chk("counter out", {15'h0000, o}, {15'h0000, cnt_out_r});
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    chk("reset out", 16'h0001, {15'h0000, cnt_out_r});
    chk("reset value", 16'h0000, count_value_r);
    // Software strobe, single byte
    setup(3'h4, 1'b0, 1'b0);
    wr(8'h03);
    pc(1'b1, 16'h0003, 1'b1);
    pc(1'b1, 16'h0002, 1'b1);
    pc(1'b1, 16'h0001, 1'b1);
    pc(1'b1, 16'h0000, 1'b0);
    pc(1'b1, 16'hffff, 1'b1);
    // Two-byte rewrite and gate hold
    setup(3'h4, 1'b0, 1'b1);
    wr(8'h05);
    wr(8'h00);
    pc(1'b1, 16'h0005, 1'b1);
    wr(8'h02);
    pc(1'b1, 16'h0004, 1'b1);
    wr(8'h00);
    pc(1'b1, 16'h0002, 1'b1);
    gate(1'b0);
    pc(1'b1, 16'h0002, 1'b1);
    gate(1'b1);
    pc(1'b1, 16'h0001, 1'b1);
    pc(1'b1, 16'h0000, 1'b0);
    // Square wave, even count
    setup(3'h3, 1'b0, 1'b0);
    wr(8'h04);
    pc(1'b1, 16'h0004, 1'b1);
    pc(1'b1, 16'h0002, 1'b1);
    pc(1'b1, 16'h0004, 1'b0);
    pc(1'b1, 16'h0002, 1'b0);
    pc(1'b1, 16'h0004, 1'b1);
    pc(1'b1, 16'h0002, 1'b1);
    pc(1'b1, 16'h0004, 1'b0);
    gate(1'b0);
    repeat (4) @(posedge core_clk);
    #1;
    chk("gate low forces out", 16'h0001, {15'h0000, cnt_out_r});
    pc(1'b1, 16'h0004, 1'b1);
    gate(1'b1);
    pc(1'b1, 16'h0004, 1'b1);
    // Square wave, odd count
    setup(3'h3, 1'b0, 1'b0);
    wr(8'h05);
    pc(1'b1, 16'h0005, 1'b1);
    pc(1'b1, 16'h0004, 1'b1);
    pc(1'b1, 16'h0002, 1'b1);
    pc(1'b1, 16'h0005, 1'b0);
    pc(1'b1, 16'h0002, 1'b0);
    pc(1'b1, 16'h0005, 1'b1);
    wr(8'h07);
    pc(1'b1, 16'h0004, 1'b1);
    pc(1'b1, 16'h0002, 1'b1);
    pc(1'b1, 16'h0007, 1'b0);
    pc(1'b1, 16'h0004, 1'b0);
    // Hardware strobe
    setup(3'h5, 1'b0, 1'b0);
    wr(8'h02);
    gate(1'b0);
    pc(1'b0, 16'h0000, 1'b1);
    chk("idle before trigger", 16'h0000, {15'h0000, counting_r});
    gate(1'b1);
    pc(1'b1, 16'h0002, 1'b1);
    pc(1'b1, 16'h0001, 1'b1);
    gate(1'b0);
    pc(1'b1, 16'h0000, 1'b0);
    pc(1'b1, 16'hffff, 1'b1);
    wr(8'h03);
    pc(1'b1, 16'hfffe, 1'b1);
    gate(1'b1);
    gate(1'b0);
    pc(1'b1, 16'h0003, 1'b1);
    // Decimal-coded zero count
    setup(3'h0, 1'b0, 1'b0);
    setup(3'h4, 1'b1, 1'b1);
    gate(1'b1);
    wr(8'h00);
    wr(8'h00);
    pc(1'b1, 16'h0000, 1'b1);
    pc(1'b1, 16'h9999, 1'b1);
    tally_and_finish();
  end
endmodule
